// >>> cba_config_access.sv
module cba_config_access #(
  parameter logic [15:0] UNSEAL_KEY0 = 16'h1111,  // readout order
  parameter logic [15:0] UNSEAL_KEY1 = 16'h2222,
  parameter logic [15:0] FULL_KEY0   = 16'h3333,
  parameter logic [15:0] FULL_KEY1   = 16'h4444,
  parameter bit          START_SEALED = 1'b1      // level after reset
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        cmd_wr,       // command space write strobe
  input  wire logic        cmd_rd,       // command space read strobe
  input  wire logic [7:0]  cmd_addr,     // command offset
  input  wire logic [7:0]  cmd_wdata,    // write byte
  input  wire logic        sub_wr,       // subcommand word strobe
  input  wire logic [15:0] sub_data,     // subcommand word
  output logic [7:0]       cmd_rdata,    // read byte
  output logic             cmd_rvalid,   // read answer strobe
  output logic             busy,         // reset restore or window copy running
  output logic [15:0]      ctrl_status,  // subcommand status word
  output logic             sealed_flag,
  output logic             full_access_state_flag
);
  import cba_pkg::*;

  // ==========================================================
  // storage
  localparam int MEM_WORDS = 1 << MEM_AW;
  localparam logic [MEM_AW-1:0] PTR_LAST = '1;
  localparam logic [4:0]        WIN_LAST = 5'h1F;
  localparam logic [5:0]        WIN_MAX  = 6'(BLK_BYTES);

  logic [7:0] data_mem [MEM_WORDS];  // no reset: nvm contents persist
  logic [7:0] win      [BLK_BYTES];  // command space window

  cba_state_t s_r;
  cba_state_t s_nxt;

  // memory and window write requests from the sequencer
  logic              mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0]        mem_wd;
  logic              win_we;
  logic [4:0]        win_wa;
  logic [7:0]        win_wd;

  // default contents of volatile blocks; keys land in the key class
  function automatic logic [7:0] rom_byte(input logic [MEM_AW-1:0] a);
    logic [MEM_AW-1:0] kb;
    logic [4:0]        o;
    kb = {KEY_CLASS[CLS_BITS-1:0], 1'b0, 5'h00};
    o  = a[4:0];
    rom_byte = 8'h00;
    if (a[MEM_AW-1:5] == kb[MEM_AW-1:5]) begin
      if (o == KEY_UNS_OFS)              rom_byte = UNSEAL_KEY0[7:0];
      else if (o == KEY_UNS_OFS + 5'h01) rom_byte = UNSEAL_KEY0[15:8];
      else if (o == KEY_UNS_OFS + 5'h02) rom_byte = UNSEAL_KEY1[7:0];
      else if (o == KEY_UNS_OFS + 5'h03) rom_byte = UNSEAL_KEY1[15:8];
      else if (o == KEY_FUL_OFS)         rom_byte = FULL_KEY0[7:0];
      else if (o == KEY_FUL_OFS + 5'h01) rom_byte = FULL_KEY0[15:8];
      else if (o == KEY_FUL_OFS + 5'h02) rom_byte = FULL_KEY1[7:0];
      else if (o == KEY_FUL_OFS + 5'h03) rom_byte = FULL_KEY1[15:8];
    end
  endfunction

  // stored key word in readout order, low byte first in storage
  function automatic logic [15:0] key_word(input logic [4:0] o);
    logic [MEM_AW-1:0] a;
    a = {KEY_CLASS[CLS_BITS-1:0], 1'b0, o};
    key_word = {data_mem[a + MEM_AW'(1)], data_mem[a]};
  endfunction

  // ==========================================================
  // block addressing
  logic [MEM_AW-1:0] blk_base;   // first byte of the selected block
  logic [7:0]        eff_cls;    // class actually addressed
  logic              win_sum_ok; // checksum matches window
  logic [7:0]        win_sum;
  logic [4:0]        woff;       // window offset of the command
  logic              in_win;
  logic              sealed;
  logic              key_blk;

  always_comb begin
    // manufacturer mode always points at info block A
    if (s_r.acc == ACC_MFG) begin
      eff_cls  = MFG_CLASS;
      blk_base = {MFG_CLASS[CLS_BITS-1:0], 1'b0, 5'h00};
    end else begin
      eff_cls  = s_r.cls;
      blk_base = {s_r.cls[CLS_BITS-1:0], s_r.blk[0], 5'h00};
    end
  end

  // complemented sum over the whole window
  always_comb begin
    win_sum = 8'h00;
    for (int i = 0; i < BLK_BYTES; i++) begin
      win_sum = win_sum + win[i];
    end
    win_sum_ok = (cmd_wdata == CSUM_BASE - win_sum);
  end

  assign woff    = cmd_addr[4:0];
  assign in_win  = (cmd_addr >= OFF_WIN_LO) && (cmd_addr <= OFF_WIN_HI);
  assign sealed  = (s_r.lvl == LV_SEALED);
  // compare only the class bits that address storage, so an alias class
  // with the top bit set cannot reach the key block unguarded
  assign key_blk = (eff_cls[CLS_BITS-1:0] == KEY_CLASS[CLS_BITS-1:0]);

  // ==========================================================
  // next state
  always_comb begin
    s_nxt  = s_r;
    mem_we = 1'b0;
    mem_wa = s_r.ptr;
    mem_wd = 8'h00;
    win_we = 1'b0;
    win_wa = woff;
    win_wd = cmd_wdata;
    s_nxt.rvalid = 1'b0;

    // read port answers in every phase
    if (cmd_rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = 8'h00;
      if (cmd_addr == OFF_CLASS && !sealed) begin
        s_nxt.rdata = s_r.cls;
      end else if (cmd_addr == OFF_BLOCK) begin
        s_nxt.rdata = s_r.blk;
      end else if (in_win && (!sealed || s_r.acc == ACC_MFG)) begin
        s_nxt.rdata = win[woff];
      end else if (cmd_addr == OFF_CSUM) begin
        s_nxt.rdata = s_r.csum;
      end else if (cmd_addr == OFF_ACC && !sealed) begin
        s_nxt.rdata = s_r.acc;
      end
    end

    unique case (s_r.phase)
      PH_INIT: begin
        // restore volatile blocks, leave nvm alone
        mem_we = cls_volatile({1'b0, s_r.ptr[MEM_AW-1:6]});
        mem_wd = rom_byte(s_r.ptr);
        s_nxt.ptr = s_r.ptr + MEM_AW'(1);
        if (s_r.ptr == PTR_LAST) begin
          s_nxt.phase = PH_LOAD;
          s_nxt.ptr   = '0;
        end
      end
      PH_LOAD: begin
        // window takes the selected block byte by byte
        win_we = 1'b1;
        win_wa = s_r.ptr[4:0];
        win_wd = data_mem[blk_base | s_r.ptr];
        s_nxt.ptr = s_r.ptr + MEM_AW'(1);
        if (s_r.ptr[4:0] == WIN_LAST) begin
          s_nxt.phase  = PH_IDLE;
          s_nxt.busy   = 1'b0;
          s_nxt.wcount = '0;
          s_nxt.ovf    = 1'b0;
        end
      end
      PH_COMMIT: begin
        // values go in as written, no range check
        mem_we = 1'b1;
        mem_wa = blk_base | s_r.ptr;
        mem_wd = win[s_r.ptr[4:0]];
        s_nxt.ptr = s_r.ptr + MEM_AW'(1);
        if (s_r.ptr[4:0] == WIN_LAST) begin
          s_nxt.phase  = PH_IDLE;
          s_nxt.busy   = 1'b0;
          s_nxt.wcount = '0;
          s_nxt.ovf    = 1'b0;
        end
      end
      PH_IDLE: begin
        if (cmd_wr) begin
          // sealed blocks selection and mode changes
          if ((cmd_addr == OFF_CLASS || cmd_addr == OFF_BLOCK ||
               cmd_addr == OFF_ACC) && !sealed) begin
            if (cmd_addr == OFF_CLASS) s_nxt.cls = cmd_wdata;
            if (cmd_addr == OFF_BLOCK) s_nxt.blk = cmd_wdata;
            if (cmd_addr == OFF_ACC)   s_nxt.acc = cmd_wdata;
            s_nxt.phase = PH_LOAD;
            s_nxt.ptr   = '0;
            s_nxt.busy  = 1'b1;
          end else if (in_win && !sealed) begin
            // byte lands at its own offset
            win_we = 1'b1;
            if (s_r.wcount == WIN_MAX) begin
              s_nxt.ovf = 1'b1;
            end else begin
              s_nxt.wcount = s_r.wcount + 6'h01;
            end
          end else if (cmd_addr == OFF_CSUM && !sealed) begin
            s_nxt.csum = cmd_wdata;
            s_nxt.ptr  = '0;
            s_nxt.busy = 1'b1;
            // key blocks only change in full access
            if (win_sum_ok && !s_r.ovf &&
                (!key_blk || s_r.lvl == LV_FULL)) begin
              s_nxt.phase = PH_COMMIT;
            end else begin
              s_nxt.phase = PH_LOAD;
            end
          end
        end
      end
      default: s_nxt.phase = PH_INIT;
    endcase

    // key pairs: any other word between the two breaks the pair
    if (sub_wr) begin
      s_nxt.pend = PD_NONE;
      if (s_r.pend == PD_UNSEAL &&
          sub_data == swap16(key_word(KEY_UNS_OFS + 5'h02))) begin
        s_nxt.lvl = LV_UNSEALED;
      end else if (s_r.pend == PD_FULL &&
                   sub_data == swap16(key_word(KEY_FUL_OFS + 5'h02))) begin
        s_nxt.lvl = LV_FULL;
      end else if (sealed &&
                   sub_data == swap16(key_word(KEY_UNS_OFS))) begin
        s_nxt.pend = PD_UNSEAL;
      end else if (s_r.lvl == LV_UNSEALED &&
                   sub_data == swap16(key_word(KEY_FUL_OFS))) begin
        s_nxt.pend = PD_FULL;
      end else if (sub_data == SEAL_CMD) begin
        s_nxt.lvl = LV_SEALED;
      end
    end

    // status word tracks the level
    s_nxt.status = 16'h0000;
    s_nxt.status[SS_BIT]  = (s_nxt.lvl == LV_SEALED);
    s_nxt.status[NFULL_BIT] = (s_nxt.lvl != LV_FULL);
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r        <= '0;
      s_r.phase  <= PH_INIT;
      s_r.busy   <= 1'b1;
      s_r.acc    <= ACC_GENERAL;
      s_r.lvl    <= START_SEALED ? LV_SEALED : LV_FULL;
      s_r.pend   <= PD_NONE;
      s_r.status <= START_SEALED ? RST_STATUS : 16'h0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // memory writes, deliberately without reset
  always_ff @(posedge clock) begin
    if (mem_we) begin
      data_mem[mem_wa] <= mem_wd;
    end
    if (win_we) begin
      win[win_wa] <= win_wd;
    end
  end

  // outputs straight from the state register; dedicated commands
  // live elsewhere and are never gated here
  assign cmd_rdata              = s_r.rdata;
  assign cmd_rvalid             = s_r.rvalid;
  assign busy                   = s_r.busy;
  assign ctrl_status            = s_r.status;
  assign sealed_flag            = s_r.status[SS_BIT];
  assign full_access_state_flag = s_r.status[NFULL_BIT];
endmodule

// >>> cba_config_access_checker.sv
module cba_config_access_checker
  import cba_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        cmd_wr,
  input wire logic        cmd_rd,
  input wire logic [7:0]  cmd_addr,
  input wire logic [7:0]  cmd_wdata,
  input wire logic        sub_wr,
  input wire logic [15:0] sub_data,
  input wire logic [7:0]  cmd_rdata,
  input wire logic        cmd_rvalid,
  input wire logic        busy,
  input wire logic [15:0] ctrl_status,
  input wire logic        sealed_flag,
  input wire logic        full_access_state_flag
);
  // one clock domain, so one default clocking
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // command bus answers, reload start and copy length
  a_read_answer: assert property (cmd_rd |=> cmd_rvalid)
    else $error("read strobe got no answer");
  a_no_stray_answer: assert property (!cmd_rd |=> !cmd_rvalid)
    else $error("answer without read strobe");
  a_unmapped_zero: assert property (cmd_rd && cmd_addr > OFF_ACC |=> cmd_rdata == 8'h00)
    else $error("unmapped offset read not zero");
  a_class_reload: assert property (!busy && cmd_wr && !sealed_flag && cmd_addr == OFF_CLASS |=> busy)
    else $error("class write did not start reload");
  a_load_bounded: assert property ($rose(busy) |-> ##[30:34] !busy)
    else $error("window copy overran");
  // ==========================================================
  // security levels
  a_sealed_refuse: assert property (!busy && cmd_wr && sealed_flag &&
    (cmd_addr == OFF_CLASS || cmd_addr == OFF_BLOCK) |=> !busy)
    else $error("sealed select write was taken");
  a_sealed_class_rd: assert property (sealed_flag && cmd_rd && cmd_addr == OFF_CLASS |=> cmd_rdata == 8'h00)
    else $error("sealed class read not zero");
  a_seal_cmd_sets: assert property (sub_wr && sub_data == SEAL_CMD |=> sealed_flag)
    else $error("seal word did not seal");
  a_unseal_by_key: assert property ($fell(sealed_flag) |-> $past(sub_wr))
    else $error("unsealed without key word");
  a_full_from_unseal: assert property ($fell(full_access_state_flag) |->
    $past(sub_wr) && !$past(sealed_flag))
    else $error("full access entered wrongly");
  a_status_flags: assert property (ctrl_status == {1'b0, full_access_state_flag, sealed_flag, 13'h0})
    else $error("status word disagrees with flags");
  // main scenarios seen
  c_key_pair: cover property (sub_wr ##1 !sub_wr ##1 sub_wr);
  c_commit: cover property (!busy && cmd_wr && cmd_addr == OFF_CSUM);
  c_load_end: cover property ($fell(busy));
endmodule

bind cba_config_access cba_config_access_checker cba_config_access_checker_inst (
  .clock(clock), .reset_n(reset_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
  .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .sub_wr(sub_wr), .sub_data(sub_data),
  .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .busy(busy),
  .ctrl_status(ctrl_status), .sealed_flag(sealed_flag),
  .full_access_state_flag(full_access_state_flag));

// >>> cba_config_access_tb.sv
module cba_config_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cba_pkg::*;
  // ==========================================================
  // keys chosen apart from all subcommand codes
  localparam logic [15:0] UK0 = 16'h12A4;
  localparam logic [15:0] UK1 = 16'h5B36;
  localparam logic [15:0] FK0 = 16'h7C81;
  localparam logic [15:0] FK1 = 16'h9E0D;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_wr, cmd_rd, cmd_rvalid, busy, sub_wr, sealed_flag, not_full;
  logic [7:0] cmd_addr, cmd_wdata, cmd_rdata, d, v, sum;
  logic [15:0] sub_data, ctrl_status;
  logic [7:0] blk [32];
  logic [7:0] nb [32];
  int seed = 84461;
  int n_mismatch = 0;
  int n_tests = 0;
  always #20 clock = ~clock;
  cba_config_access #(.UNSEAL_KEY0(UK0), .UNSEAL_KEY1(UK1), .FULL_KEY0(FK0),
    .FULL_KEY1(FK1)) cba_config_access_inst (.clock(clock), .reset_n(reset_n),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .sub_wr(sub_wr), .sub_data(sub_data), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .busy(busy), .ctrl_status(ctrl_status),
    .sealed_flag(sealed_flag), .full_access_state_flag(not_full));
  cba_host_model cba_host_model_inst (.clock(clock), .cmd_rdata(cmd_rdata),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .sub_wr(sub_wr), .sub_data(sub_data));
  // ==========================================================
  // verdict and comparison
  task test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  // host sends each key byte swapped
  function automatic logic [15:0] sw(input logic [15:0] k);
    return {k[7:0], k[15:8]};
  endfunction
  // ==========================================================
  // bus helpers, writes only once idle
  task idle;
    for (int k = 0; k < 9000; k++) begin
      if (busy === 1'b0) return;
      @(negedge clock);
    end
    chk("busy", 16'h0, 16'(busy));
    test_done();
  endtask
  task w(input logic [7:0] a, input logic [7:0] x);
    idle();
    cba_host_model_inst.wr(a, x);
  endtask
  task sel(input logic [7:0] b);
    w(OFF_ACC, ACC_GENERAL);
    w(OFF_CLASS, 8'h52);
    w(OFF_BLOCK, b);
  endtask
  task vrfy;
    sel(8'h01);
    sel(8'h00);
    idle();
    for (int i = 0; i < 32; i++) begin
      cba_host_model_inst.rd(OFF_WIN_LO + 8'(i), d);
      chk("window", {8'h00, blk[i]}, {8'h00, d});
    end
  endtask
  // random block, optional extra write, checksum for the last 32
  task fill(input bit extra);
    sum = 8'h00;
    for (int i = 0; i < 32; i++) begin
      nb[i] = 8'($random(seed));
      sum = sum + nb[i];
      w(OFF_WIN_LO + 8'(i), nb[i]);
    end
    if (extra) w(OFF_WIN_LO, nb[0]);
    w(OFF_CSUM, CSUM_BASE - sum);
  endtask
  // key block edit with a correct checksum; only full access may commit
  task key_edit(input logic [7:0] e);
    v = ~UK0[7:0];
    sum = v + UK0[15:8] + UK1[7:0] + UK1[15:8] + FK0[7:0] + FK0[15:8] +
      FK1[7:0] + FK1[15:8];
    w(OFF_ACC, ACC_GENERAL);
    w(OFF_CLASS, KEY_CLASS);
    w(OFF_BLOCK, 8'h00);
    w(OFF_WIN_LO, v);
    w(OFF_CSUM, CSUM_BASE - sum);
    // reload so the read shows storage, not the edited window
    w(OFF_BLOCK, 8'h00);
    idle();
    cba_host_model_inst.rd(OFF_WIN_LO, d);
    chk("key_block", {8'h00, e}, {8'h00, d});
  endtask
  task unseal;
    cba_host_model_inst.sub(sw(UK0));
    cba_host_model_inst.sub(sw(UK1));
    @(negedge clock);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(negedge clock);
    chk("busy_reset", 16'h1, 16'(busy));
    chk("status_reset", RST_STATUS, ctrl_status);
    reset_n = 1'b1;
    w(OFF_CLASS, 8'h52);
    idle();
    cba_host_model_inst.rd(OFF_CLASS, d);
    chk("sealed_class", 16'h0, {8'h00, d});
    cba_host_model_inst.rd(OFF_WIN_LO, d);
    chk("sealed_window", 16'h0, {8'h00, d});
    cba_host_model_inst.rd(8'h7F, d);
    chk("unmapped", 16'h0, {8'h00, d});
    chk("rvalid", 16'h1, 16'(cmd_rvalid));
    cba_host_model_inst.sub(sw(UK0));
    cba_host_model_inst.sub(16'h0001);
    cba_host_model_inst.sub(sw(UK1));
    cba_host_model_inst.sub(UK0);
    cba_host_model_inst.sub(UK1);
    @(negedge clock);
    chk("broken_pair", 16'h1, 16'(sealed_flag));
    unseal();
    chk("unsealed", 16'h0, 16'(sealed_flag));
    key_edit(UK0[7:0]);
    cba_host_model_inst.sub(sw(FK0));
    cba_host_model_inst.sub(sw(FK1));
    @(negedge clock);
    chk("full_access", 16'h0, 16'(not_full));
    key_edit(~UK0[7:0]);
    sel(8'h00);
    fill(1'b0);
    blk = nb;
    vrfy();
    v = ~blk[3];
    sum = sum - blk[3] + v;
    w(OFF_WIN_LO + 8'h03, v);
    w(OFF_CSUM, CSUM_BASE - sum);
    blk[3] = v;
    vrfy();
    w(OFF_WIN_LO + 8'h03, ~v);
    w(OFF_CSUM, CSUM_BASE - sum);
    idle();
    cba_host_model_inst.rd(OFF_WIN_LO + 8'h03, d);
    chk("bad_checksum", {8'h00, v}, {8'h00, d});
    fill(1'b1);
    vrfy();
    // manufacturer block: commit while unsealed, read back once sealed
    w(OFF_ACC, ACC_MFG);
    fill(1'b0);
    w(OFF_ACC, ACC_MFG);
    cba_host_model_inst.sub(SEAL_CMD);
    @(negedge clock);
    chk("sealed_again", 16'h1, 16'(sealed_flag));
    w(OFF_WIN_LO, ~nb[0]);
    cba_host_model_inst.rd(OFF_WIN_LO, d);
    chk("mfg_sealed_read", {8'h00, nb[0]}, {8'h00, d});
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    chk("busy_reset2", 16'h1, 16'(busy));
    reset_n = 1'b1;
    idle();
    unseal();
    vrfy();
    test_done();
  end
endmodule

// >>> cba_host_model.sv
module cba_host_model (
  input  wire logic        clock,
  input  wire logic [7:0]  cmd_rdata,
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic [7:0]       cmd_addr,
  output logic [7:0]       cmd_wdata,
  output logic             sub_wr,
  output logic [15:0]      sub_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // quiet bus from time zero
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    sub_wr = 1'b0;
    sub_data = 16'h0000;
  end
  // one byte strobe, data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    cmd_addr = a;
    cmd_wdata = d;
    cmd_wr = 1'b1;
    @(negedge clock);
    cmd_wr = 1'b0;
    cmd_wdata = ~d;
  endtask
  // answer is registered, so take it one cycle on
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    cmd_addr = a;
    cmd_rd = 1'b1;
    @(negedge clock);
    cmd_rd = 1'b0;
    d = cmd_rdata;
  endtask
  // subcommand word, key words go in as given
  task automatic sub(input logic [15:0] w);
    @(negedge clock);
    sub_data = w;
    sub_wr = 1'b1;
    @(negedge clock);
    sub_wr = 1'b0;
    sub_data = ~w;
  endtask
endmodule

// >>> cba_pkg.sv
package cba_pkg;
  // ==========================================================
  // command space offsets
  localparam logic [7:0] OFF_CLASS   = 8'h3E;  // class select
  localparam logic [7:0] OFF_BLOCK   = 8'h3F;  // block index select
  localparam logic [7:0] OFF_WIN_LO  = 8'h40;  // first window byte
  localparam logic [7:0] OFF_WIN_HI  = 8'h5F;  // last window byte
  localparam logic [7:0] OFF_CSUM    = 8'h60;  // commit checksum
  localparam logic [7:0] OFF_ACC     = 8'h61;  // access select
  // ==========================================================
  // field values and layout
  localparam logic [7:0] ACC_GENERAL = 8'h00;  // general data blocks
  localparam logic [7:0] ACC_MFG     = 8'h01;  // manufacturer info mode
  localparam logic [7:0] CSUM_BASE   = 8'hFF;  // complement base
  localparam logic [7:0] MFG_CLASS   = 8'h3A;  // manufacturer info class
  localparam logic [7:0] KEY_CLASS   = 8'h70;  // security codes class
  localparam logic [4:0] KEY_UNS_OFS = 5'h00;  // unseal key words
  localparam logic [4:0] KEY_FUL_OFS = 5'h04;  // full access key words
  localparam int         BLK_BYTES   = 32;     // window size
  localparam int         CLS_BITS    = 7;      // class bits used
  localparam int         MEM_AW      = CLS_BITS + 1 + 5;
  localparam int         SS_BIT      = 13;     // status: sealed
  localparam int         NFULL_BIT   = 14;     // status: not full access
  localparam logic [15:0] SEAL_CMD   = 16'h0020;  // seal subcommand
  localparam logic [15:0] RST_STATUS = 16'h6000;  // sealed, not full
  // volatile classes, restored from ROM at reset
  localparam logic [127:0] RAM_CLASS_MAP = (128'h1 << 2) | (128'h1 << 36) |
    (128'h1 << 49) | (128'h1 << 68) | (128'h1 << 81) | (128'h1 << 89) |
    (128'h1 << 112);
  // ==========================================================
  // types
  typedef enum logic [1:0] {PH_INIT, PH_IDLE, PH_LOAD, PH_COMMIT} cba_phase_t;
  typedef enum logic [1:0] {LV_FULL, LV_UNSEALED, LV_SEALED} cba_level_t;
  typedef enum logic [1:0] {PD_NONE, PD_UNSEAL, PD_FULL} cba_pend_t;
  typedef struct packed {
    cba_phase_t        phase;    // sequencer phase
    logic [MEM_AW-1:0] ptr;      // copy pointer
    logic [7:0]        cls;      // selected class
    logic [7:0]        blk;      // selected block index
    logic [7:0]        acc;      // access select
    logic [7:0]        csum;     // last checksum written
    logic [5:0]        wcount;   // window writes since last load or commit
    logic              ovf;      // overlong transfer seen
    cba_level_t        lvl;      // security level
    cba_pend_t         pend;     // first key word accepted
    logic [7:0]        rdata;    // read answer
    logic              rvalid;   // read answer strobe
    logic              busy;     // copy in progress
    logic [15:0]       status;   // subcommand status word
  } cba_state_t;
  // ==========================================================
  // helpers
  function automatic logic [15:0] swap16(input logic [15:0] w);
    swap16 = {w[7:0], w[15:8]};
  endfunction
  function automatic logic cls_volatile(input logic [7:0] c);
    cls_volatile = RAM_CLASS_MAP[c[CLS_BITS-1:0]];
  endfunction
endpackage
